//--- shared/pzb_defs.svh
// Constants for the page zero status and flag bank.
// Assumes one clock domain and a byte-wide register port.
`ifndef PZB_DEFS_SVH
`define PZB_DEFS_SVH

`define PZB_OFS_PAGE        8'h01
`define PZB_OFS_PN_LO       8'h02
`define PZB_OFS_PN_HI       8'h03
`define PZB_OFS_GRADE       8'h04
`define PZB_OFS_REV         8'h05
`define PZB_OFS_TOOL0       8'h06
`define PZB_OFS_TOOL1       8'h07
`define PZB_OFS_TOOL2       8'h08
`define PZB_OFS_TEMP        8'h09
`define PZB_OFS_PKG         8'h0a
`define PZB_OFS_ADDR        8'h0b
`define PZB_OFS_SYS_LIVE    8'h0c
`define PZB_OFS_IN_LIVE     8'h0d
`define PZB_OFS_LOOP_LIVE   8'h0e
`define PZB_OFS_CAL_LIVE    8'h0f
`define PZB_OFS_SYS_STICKY  8'h11
`define PZB_OFS_IN_STICKY   8'h12
`define PZB_OFS_LOOP_STICKY 8'h13
`define PZB_OFS_CAL_STICKY  8'h14
`define PZB_OFS_HOLD_CTL    8'h16
`define PZB_OFS_SYS_MASK    8'h17
`define PZB_OFS_IN_MASK     8'h18
`define PZB_OFS_LOOP_MASK   8'h19
`define PZB_OFS_CAL_MASK    8'h1a

// Implemented bits of the system status byte: 0,1,2,3,5
`define PZB_SYS_BITS        8'h2f
`define PZB_CAL_BITS        8'hf0
`define PZB_HOLD_CTL_BITS   8'h0f

`define PZB_RST_PAGE        8'h00
`define PZB_RST_ADDR        7'h68
`define PZB_RST_SYS_MASK    8'h35
`define PZB_RST_IN_MASK     8'h00
`define PZB_RST_LOOP_MASK   8'h00
`define PZB_RST_CAL_MASK    8'h00

`endif

//--- shared/pzb_pkg.sv
// Types for the page zero status and flag bank.
// Assumes pzb_defs.svh supplies the numeric constants.
package pzb_pkg;
	typedef logic [7:0] pzb_byte_t;
	typedef logic [7:0] pzb_page_t;
endpackage

//--- src/pzb_bank.sv
// Page zero register bank: page selector, identity bytes, live status,
// sticky flags with write-zero clear, and interrupt masks.
// Assumes a serial-port front end on the same clock gives one-cycle
// read/write strobes with a byte address and data; status inputs are
// asynchronous and are synchronised here.
//
// How it works
// - Eight-bit page selector picks one of 256.
// - Page selector answers at low address 0x01.
// - Read gives page, write switches page at once.
// - Read-only part number, one nibble per digit.
// - Read-only grade code, 0..3 mean A..D.
// - Read-only revision, 0 means A upward.
// - Writable 7-bit target address in bits 6:0.
// - Bit 0 high while system calibrates.
// - Bits 1,2 show reference pins/input absent.
// - Bit 3 shows reference lock trouble.
// - Bit 5 shows serial bus timeout.
// - Live per-input absent bits 3:0, unlatched.
// - Live per-input out-of-frequency bits 7:4.
// - Loop unlocked bits 3:0, loop A lowest.
// - Loop holdover bits 7:4, loop A bit 4.
// - Loop calibration busy bits 7:4.
// - System flags sticky until host writes zero.
// - Per-input sticky absent and frequency flags.
// - Per-loop sticky unlock and holdover flags.
// - Per-loop sticky calibration flags, write-zero clear.
// - Mask bit 0 blocks calibrating flag interrupt.
// - Mask bits 1,2,5 block reference and timeout.
// - Per-input mask blocks absent and frequency flags.
`timescale 1ns/1ps
`include "pzb_defs.svh"
`default_nettype none

module pzb_bank #(
	parameter logic [15:0] PART_NUMBER = 16'h1234, // Arbitrary value
	parameter logic [7:0]  GRADE_CODE  = 8'h00,
	parameter logic [7:0]  REV_CODE    = 8'h00,
	parameter logic [7:0]  TEMP_CODE   = 8'h00,
	parameter logic [7:0]  PKG_CODE    = 8'h00
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic      [7:0] active_page,
	output logic      [6:0] serial_target_addr,
	output logic      [3:0] unlock_during_holdover,
	input  wire logic       system_calibrating,
	input  wire logic       ref_pins_no_signal,
	input  wire logic       ref_input_no_signal,
	input  wire logic       ref_lock_problem,
	input  wire logic       serial_bus_timeout,
	input  wire logic [3:0] input_signal_absent,
	input  wire logic [3:0] input_freq_out_of_range,
	input  wire logic [3:0] loop_unlocked,
	input  wire logic [3:0] loop_holdover,
	input  wire logic [3:0] loop_calibrating,
	output logic            irq
);

	pzb_pkg::pzb_page_t page_q;
	pzb_pkg::pzb_byte_t tool0_q, tool1_q, tool2_q;
	pzb_pkg::pzb_byte_t hold_ctl_q;
	pzb_pkg::pzb_byte_t sys_mask_q, in_mask_q, loop_mask_q, cal_mask_q;
	logic [6:0]         addr_q;
	pzb_pkg::pzb_byte_t sys_sticky_q, in_sticky_q;
	pzb_pkg::pzb_byte_t loop_sticky_q, cal_sticky_q;
	pzb_pkg::pzb_byte_t rdata_q;
	logic               irq_q;

	// Raw asynchronous status, packed into register layout
	logic [31:0] raw_status;
	logic [31:0] sync1_q;
	logic [31:0] sync2_q;
	pzb_pkg::pzb_byte_t sys_live, in_live, loop_live, cal_live;

	assign raw_status = {
		loop_calibrating, 4'h0,
		loop_holdover, loop_unlocked,
		input_freq_out_of_range, input_signal_absent,
		2'b00, serial_bus_timeout, 1'b0,
		ref_lock_problem, ref_input_no_signal,
		ref_pins_no_signal, system_calibrating
	};

	// Two-stage synchroniser; only stage two feeds logic
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_q <= 32'h0000_0000;
			sync2_q <= 32'h0000_0000;
		end else begin
			sync1_q <= raw_status;
			sync2_q <= sync1_q;
		end
	end

	assign sys_live  = sync2_q[7:0] & `PZB_SYS_BITS;
	assign in_live   = sync2_q[15:8];
	assign loop_live = sync2_q[23:16];
	assign cal_live  = sync2_q[31:24] & `PZB_CAL_BITS;

	// Only the page selector is mirrored on every page; identity bytes are page zero only,
	// so decode looks only at the low byte of the address.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	function automatic pzb_pkg::pzb_byte_t sticky_next(
		input pzb_pkg::pzb_byte_t cur,
		input pzb_pkg::pzb_byte_t live,
		input logic               wr,
		input pzb_pkg::pzb_byte_t wdata
	);
		pzb_pkg::pzb_byte_t kept;
		kept = wr ? (cur & wdata) : cur; // Zero clears, one keeps
		sticky_next = kept | live;       // Set wins over clear
	endfunction

	// Page selector
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			page_q <= `PZB_RST_PAGE;
		end else if (reg_wr && hit(reg_addr, `PZB_OFS_PAGE)) begin
			page_q <= reg_wdata;
		end
	end

	// Plain read/write configuration bytes, page zero only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tool0_q     <= 8'h00;
			tool1_q     <= 8'h00;
			tool2_q     <= 8'h00;
			addr_q      <= `PZB_RST_ADDR;
			hold_ctl_q  <= 8'h00;
			sys_mask_q  <= `PZB_RST_SYS_MASK;
			in_mask_q   <= `PZB_RST_IN_MASK;
			loop_mask_q <= `PZB_RST_LOOP_MASK;
			cal_mask_q  <= `PZB_RST_CAL_MASK;
		end else if (reg_wr && page_q == 8'h00) begin
			if (hit(reg_addr, `PZB_OFS_TOOL0))
				tool0_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_TOOL1))
				tool1_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_TOOL2))
				tool2_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_ADDR))
				addr_q <= reg_wdata[6:0];
			if (hit(reg_addr, `PZB_OFS_HOLD_CTL))
				hold_ctl_q <= reg_wdata & `PZB_HOLD_CTL_BITS;
			if (hit(reg_addr, `PZB_OFS_SYS_MASK))
				sys_mask_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_IN_MASK))
				in_mask_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_LOOP_MASK))
				loop_mask_q <= reg_wdata;
			if (hit(reg_addr, `PZB_OFS_CAL_MASK))
				cal_mask_q <= reg_wdata & `PZB_CAL_BITS;
		end
	end

	// Sticky flags: live status sets, a written zero clears
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sys_sticky_q  <= 8'h00;
			in_sticky_q   <= 8'h00;
			loop_sticky_q <= 8'h00;
			cal_sticky_q  <= 8'h00;
		end else begin
			sys_sticky_q <= sticky_next(sys_sticky_q, sys_live,
				reg_wr && page_q == 8'h00 &&
				hit(reg_addr, `PZB_OFS_SYS_STICKY), reg_wdata);
			in_sticky_q <= sticky_next(in_sticky_q, in_live,
				reg_wr && page_q == 8'h00 &&
				hit(reg_addr, `PZB_OFS_IN_STICKY), reg_wdata);
			loop_sticky_q <= sticky_next(loop_sticky_q, loop_live,
				reg_wr && page_q == 8'h00 &&
				hit(reg_addr, `PZB_OFS_LOOP_STICKY), reg_wdata);
			cal_sticky_q <= sticky_next(cal_sticky_q, cal_live,
				reg_wr && page_q == 8'h00 &&
				hit(reg_addr, `PZB_OFS_CAL_STICKY), reg_wdata);
		end
	end

	// Registered interrupt: one cycle behind the flags, glitch free
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sys_sticky_q & ~sys_mask_q) |
			         |(in_sticky_q & ~in_mask_q) |
			         |(loop_sticky_q & ~loop_mask_q) |
			         |(cal_sticky_q & ~cal_mask_q);
		end
	end

	// Read data: registered one cycle after the read strobe; other
	// pages answer only at the selector, elsewhere read zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			if (hit(reg_addr, `PZB_OFS_PAGE)) begin
				rdata_q <= page_q;
			end else if (page_q != 8'h00) begin
				rdata_q <= 8'h00;
			end else begin
				case (reg_addr)
				`PZB_OFS_PN_LO:       rdata_q <= PART_NUMBER[7:0];
				`PZB_OFS_PN_HI:       rdata_q <= PART_NUMBER[15:8];
				`PZB_OFS_GRADE:       rdata_q <= GRADE_CODE;
				`PZB_OFS_REV:         rdata_q <= REV_CODE;
				`PZB_OFS_TOOL0:       rdata_q <= tool0_q;
				`PZB_OFS_TOOL1:       rdata_q <= tool1_q;
				`PZB_OFS_TOOL2:       rdata_q <= tool2_q;
				`PZB_OFS_TEMP:        rdata_q <= TEMP_CODE;
				`PZB_OFS_PKG:         rdata_q <= PKG_CODE;
				`PZB_OFS_ADDR:        rdata_q <= {1'b0, addr_q};
				`PZB_OFS_SYS_LIVE:    rdata_q <= sys_live;
				`PZB_OFS_IN_LIVE:     rdata_q <= in_live;
				`PZB_OFS_LOOP_LIVE:   rdata_q <= loop_live;
				`PZB_OFS_CAL_LIVE:    rdata_q <= cal_live;
				`PZB_OFS_SYS_STICKY:  rdata_q <= sys_sticky_q;
				`PZB_OFS_IN_STICKY:   rdata_q <= in_sticky_q;
				`PZB_OFS_LOOP_STICKY: rdata_q <= loop_sticky_q;
				`PZB_OFS_CAL_STICKY:  rdata_q <= cal_sticky_q;
				`PZB_OFS_HOLD_CTL:    rdata_q <= hold_ctl_q;
				`PZB_OFS_SYS_MASK:    rdata_q <= sys_mask_q;
				`PZB_OFS_IN_MASK:     rdata_q <= in_mask_q;
				`PZB_OFS_LOOP_MASK:   rdata_q <= loop_mask_q;
				`PZB_OFS_CAL_MASK:    rdata_q <= cal_mask_q;
				default:              rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata              = rdata_q;
	assign active_page            = page_q;
	assign serial_target_addr     = addr_q;
	assign unlock_during_holdover = hold_ctl_q[3:0];
	assign irq                    = irq_q;

endmodule

`default_nettype wire

//--- verif/pzb_bank_props.sv
// Port checker for the page zero bank, bound onto every instance.
// Assumes single-cycle strobes and reads answered one edge later.
`timescale 1ns/1ps
`include "pzb_defs.svh"
`default_nettype none
module pzb_bank_props #(
	parameter logic [15:0] PART_NUMBER = 16'h1234
) (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] active_page,
	input wire logic [6:0] serial_target_addr,
	input wire logic       system_calibrating,
	input wire logic       ref_lock_problem
);
	// Reads of page zero decide most of the bank's answers
	logic rd0;
	assign rd0 = reg_rd && active_page == 8'h00;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	chk_page_write: assert property (
		reg_wr && reg_addr == `PZB_OFS_PAGE |=> active_page == $past(reg_wdata))
		else $error("page write not taken");
	chk_page_read: assert property (
		reg_rd && reg_addr == `PZB_OFS_PAGE |=> reg_rdata == $past(active_page))
		else $error("page read wrong");
	chk_addr_write: assert property (
		reg_wr && reg_addr == `PZB_OFS_ADDR && active_page == 8'h00
		|=> serial_target_addr == $past(reg_wdata[6:0])) else $error("addr lost");
	chk_addr_hold: assert property (
		!(reg_wr && reg_addr == `PZB_OFS_ADDR) |=> $stable(serial_target_addr))
		else $error("addr changed unasked");
	chk_rdata_stands: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	chk_part_low: assert property (
		rd0 && reg_addr == `PZB_OFS_PN_LO |=> reg_rdata == PART_NUMBER[7:0])
		else $error("part number wrong");
	chk_off_page: assert property (
		reg_rd && reg_addr != `PZB_OFS_PAGE && active_page != 8'h00
		|=> reg_rdata == 8'h00) else $error("other page not zero");
	chk_calib_live: assert property (
		system_calibrating [*4] ##0 (rd0 && reg_addr == `PZB_OFS_SYS_LIVE)
		|=> reg_rdata[0]) else $error("calibrating bit low");
	chk_lock_sticky: assert property (
		ref_lock_problem [*5] ##0 (rd0 && reg_addr == `PZB_OFS_SYS_STICKY)
		|=> reg_rdata[3]) else $error("lock flag not latched");
endmodule
bind pzb_bank pzb_bank_props #(.PART_NUMBER(PART_NUMBER)) pzb_bank_props_inst (
	.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.active_page(active_page), .serial_target_addr(serial_target_addr),
	.system_calibrating(system_calibrating),
	.ref_lock_problem(ref_lock_problem));
`default_nettype wire

//--- verif/pzb_host.sv
// Host side of the register port: byte reads and writes.
// Assumes the bank samples strobes on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module pzb_host (
	input  wire logic       clock,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Write zero is also how flags are cleared; lines invert once idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Data is registered, so it is settled one falling edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

//--- verif/pzb_bank_test.sv
// Self-checking bench for the page zero bank.
// Assumes the host model drives the port and this module the status pins.
`timescale 1ns/1ps
`include "pzb_defs.svh"
`default_nettype none
module pzb_bank_test;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       wr, rd, irq;
	logic [7:0] addr, wdata, rdata, page, v, ss, is, ls, cs;
	logic [6:0] tgt;
	logic [3:0] hold;
	int         mismatches = 0;
	int         samples_checked = 0;
	logic [7:0] lofs [4] = '{`PZB_OFS_SYS_LIVE, `PZB_OFS_IN_LIVE,
		`PZB_OFS_LOOP_LIVE, `PZB_OFS_CAL_LIVE};
	logic [7:0] lexp [4] = '{8'h2f, 8'ha5, 8'hc3, 8'hf0};
	always #2 clock = ~clock;
	pzb_bank pzb_bank_inst (.clock(clock), .rst(rst), .reg_wr(wr),
		.reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.active_page(page), .serial_target_addr(tgt),
		.unlock_during_holdover(hold), .system_calibrating(ss[0]),
		.ref_pins_no_signal(ss[1]), .ref_input_no_signal(ss[2]),
		.ref_lock_problem(ss[3]), .serial_bus_timeout(ss[5]),
		.input_signal_absent(is[3:0]), .input_freq_out_of_range(is[7:4]),
		.loop_unlocked(ls[3:0]), .loop_holdover(ls[7:4]),
		.loop_calibrating(cs[7:4]), .irq(irq));
	pzb_host pzb_host_inst (.clock(clock), .reg_wr(wr), .reg_rd(rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		pzb_host_inst.rd(a, v);
		check(v, e);
	endtask
	// Status pins change on a falling edge, then settle past sync and latch
	task automatic st(input logic [7:0] s, i, l, c);
		@(negedge clock);
		{ss, is, ls, cs} = {s, i, l, c};
		repeat (4) @(negedge clock);
	endtask
	task automatic complete_run;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		complete_run();
	end
	initial begin
		{ss, is, ls, cs} = 32'h0;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		check(page, `PZB_RST_PAGE);
		check({1'b0, tgt}, {1'b0, `PZB_RST_ADDR});
		rchk(`PZB_OFS_SYS_MASK, `PZB_RST_SYS_MASK);
		rchk(`PZB_OFS_GRADE, 8'h00);
		rchk(`PZB_OFS_REV, 8'h00);
		rchk(`PZB_OFS_PN_HI, 8'h12);
		pzb_host_inst.wr(`PZB_OFS_PN_LO, 8'hff);
		rchk(`PZB_OFS_PN_LO, 8'h34);
		for (int i = 0; i < 3; i++) begin
			pzb_host_inst.wr(`PZB_OFS_TOOL0 + 8'(i), 8'ha5 ^ 8'(i));
			rchk(`PZB_OFS_TOOL0 + 8'(i), 8'ha5 ^ 8'(i));
		end
		pzb_host_inst.wr(`PZB_OFS_ADDR, 8'hd5);
		check({1'b0, tgt}, 8'h55);
		// Hold control drives a port of its own; only the low nibble exists
		pzb_host_inst.wr(`PZB_OFS_HOLD_CTL, 8'hff);
		check({4'h0, hold}, 8'h0f);
		rchk(`PZB_OFS_HOLD_CTL, 8'h0f);
		// The top page must still reach the selector and hide the bank
		pzb_host_inst.wr(`PZB_OFS_PAGE, 8'hff);
		rchk(`PZB_OFS_PAGE, 8'hff);
		rchk(`PZB_OFS_PN_LO, 8'h00);
		pzb_host_inst.wr(`PZB_OFS_PAGE, 8'h00);
		check(page, 8'h00);
		st(8'h2f, 8'ha5, 8'hc3, 8'hf0);
		for (int i = 0; i < 4; i++) rchk(lofs[i], lexp[i]);
		st(8'h00, 8'h00, 8'h00, 8'h00);
		check({7'h0, irq}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			rchk(lofs[i], 8'h00);
			pzb_host_inst.wr(lofs[i] + 8'h05, 8'hff);
			rchk(lofs[i] + 8'h05, lexp[i]);
			pzb_host_inst.wr(lofs[i] + 8'h05, 8'h00);
			rchk(lofs[i] + 8'h05, 8'h00);
		end
		check({7'h0, irq}, 8'h00);
		st(8'h01, 8'h00, 8'h00, 8'h00);
		pzb_host_inst.wr(`PZB_OFS_SYS_STICKY, 8'h00);
		rchk(`PZB_OFS_SYS_STICKY, 8'h01);
		check({7'h0, irq}, 8'h00);
		pzb_host_inst.wr(`PZB_OFS_SYS_MASK, 8'h00);
		@(negedge clock);
		check({7'h0, irq}, 8'h01);
		st(8'h00, 8'h00, 8'h00, 8'h00);
		pzb_host_inst.wr(`PZB_OFS_SYS_STICKY, 8'h00);
		pzb_host_inst.wr(`PZB_OFS_SYS_MASK, 8'h2f);
		pzb_host_inst.wr(`PZB_OFS_IN_MASK, 8'hff);
		st(8'h2e, 8'hff, 8'h00, 8'h00);
		check({7'h0, irq}, 8'h00);
		rchk(`PZB_OFS_IN_STICKY, 8'hff);
		rchk(`PZB_OFS_SYS_STICKY, 8'h2e);
		complete_run();
	end
endmodule
`default_nettype wire
